// ==== rtl/ecfl_loader.sv ====
// configuration loader: image signature check, field copy, register slave
`timescale 1ns/1ps
`default_nettype none
module ecfl_loader
  import ecfl_pkg::*;
#(
  parameter logic [9:0] F2_OFS  = 10'h010,
  parameter logic [9:0] F3_OFS  = 10'h014,
  parameter logic [9:0] GPIO_OFS = 10'h018,
  parameter int         RAM_DEPTH = 128,
  parameter int         RAM_AW    = 7
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   por_rst,
  input  wire ecfl_pkg::ecfl_axi_req_t axi_req,
  output var  ecfl_pkg::ecfl_axi_rsp_t axi_rsp,
  output var  ecfl_pkg::ecfl_mem_req_t mem_req,
  input  wire ecfl_pkg::ecfl_mem_rsp_t mem_rsp,
  input  wire logic [RAM_AW-1:0]      desc_rd_idx,
  output logic      [31:0]            desc_rd_data,
  output logic                        desc_src_ram,
  output logic                        cfg_done,
  output logic      [31:0]            usb_setup_reg_a,
  output logic      [31:0]            usb_setup_reg_b,
  output logic      [31:0]            usb_setup_reg_c,
  output logic      [31:0]            mac_control_reg,
  output logic      [31:0]            hardware_setup_reg,
  output logic      [31:0]            pin_setup_reg_a,
  output logic      [31:0]            pin_setup_reg_b
);
  import ecfl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // register index from a byte address, 4'hF for unmapped
  function automatic logic [3:0] reg_idx(input logic [7:0] a);
    logic [3:0] r;
    r = 4'hF;
    unique case (a)
      OFS_USB_A:    r = 4'h0;
      OFS_USB_B:    r = 4'h1;
      OFS_USB_C:    r = 4'h2;
      OFS_MAC:      r = 4'h3;
      OFS_HW:       r = 4'h4;
      OFS_PIN_A:    r = 4'h5;
      OFS_PIN_B:    r = 4'h6;
      OFS_ATTR:     r = 4'h7;
      OFS_RAM_ADDR: r = 4'h8;
      OFS_RAM_DATA: r = 4'h9;
      OFS_STATUS:   r = 4'hA;
      default:      r = 4'hF;
    endcase
    return r;
  endfunction

  // byte-lane merge, bits outside the mask stay zero
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r & msk;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  ecfl_ld_t          ld_st_r;
  logic [3:0]        byte_cnt_r;
  logic [9:0]        base_r;
  logic [127:0]      img_r;
  logic [1:0]        src_r;
  logic              mem_req_r;
  logic              mem_otp_r;
  logic [9:0]        mem_addr_r;
  logic              done_r;
  logic [31:0]       usb_a_r, usb_b_r, usb_c_r, mac_r, hw_r, pin_a_r, pin_b_r, attr_r;
  logic [RAM_AW-1:0] ram_addr_r;
  logic              attr_seen_r;
  logic              ram_early_r;
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic [31:0]       ram_rd_b;
  logic [9:0]        fetch_ofs;
  logic              rst_all;
  logic              rst_ctl;
  logic              wr_fire;
  logic              rd_fire;
  logic [3:0]        wr_idx;
  logic [3:0]        rd_idx;
  logic              ram_wr;
  logic              attr_ok;
  logic [31:0]       f2;
  logic [31:0]       f3;
  logic [63:0]       gpio;

  // protected registers only fall back on power-on reset
  assign rst_all = sys_rst | por_rst;
  assign rst_ctl = por_rst | (sys_rst & ~hw_r[HW_PROT]);

  assign wr_fire = awready_r & axi_req.awvalid & wready_r & axi_req.wvalid;
  assign rd_fire = arready_r & axi_req.arvalid;
  assign wr_idx  = reg_idx(axi_req.awaddr);
  assign rd_idx  = reg_idx(axi_req.araddr);
  assign ram_wr  = wr_fire && wr_idx == 4'h9;
  assign attr_ok = attr_seen_r & ~ram_early_r;

  assign f2   = img_r[31:0];
  assign f3   = img_r[63:32];
  assign gpio = img_r[127:64];

  ////////////////////////////////////////////////////////////////////////////
  // image loader

  // byte offset of the next fetched byte, little-endian words
  always_comb
  begin
    if (byte_cnt_r < 4'd4)
      fetch_ofs = F2_OFS + {6'h00, byte_cnt_r};
    else if (byte_cnt_r < 4'd8)
      fetch_ofs = F3_OFS + {6'h00, byte_cnt_r} - 10'h004;
    else
      fetch_ofs = GPIO_OFS + {6'h00, byte_cnt_r} - 10'h008;
  end

  // signature first, then 16 image bytes, then one apply cycle
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      ld_st_r    <= LD_EE_SIG;
      byte_cnt_r <= 4'h0;
      base_r     <= BASE_EE;
      img_r      <= '0;
      src_r      <= SRC_NONE;
      mem_req_r  <= 1'b0;
      mem_otp_r  <= 1'b0;
      mem_addr_r <= SIG_ADDR;
    end
    else
    begin
      unique case (ld_st_r)
        LD_EE_SIG:
        begin
          if (!mem_req_r)
          begin
            mem_req_r  <= 1'b1; // signature before anything else
            mem_otp_r  <= 1'b0;
            mem_addr_r <= SIG_ADDR;
          end
          else if (mem_rsp.ack)
          begin
            mem_req_r <= 1'b0;
            if (mem_rsp.data == SIG_EE)
            begin
              base_r  <= BASE_EE;
              src_r   <= SRC_EE;
              ld_st_r <= LD_FETCH;
            end
            else
              ld_st_r <= LD_OTP_SIG; // eeprom treated as absent
          end
        end
        LD_OTP_SIG:
        begin
          if (!mem_req_r)
          begin
            mem_req_r  <= 1'b1;
            mem_otp_r  <= 1'b1;
            mem_addr_r <= SIG_ADDR;
          end
          else if (mem_rsp.ack)
          begin
            mem_req_r <= 1'b0;
            if (mem_rsp.data == SIG_OTP_LO || mem_rsp.data == SIG_OTP_HI)
            begin
              base_r  <= (mem_rsp.data == SIG_OTP_LO) ? BASE_OTP_LO : BASE_OTP_HI;
              src_r   <= SRC_OTP;
              ld_st_r <= LD_FETCH;
            end
            else
              ld_st_r <= LD_DONE; // blank otp: no load at all
          end
        end
        LD_FETCH:
        begin
          if (!mem_req_r)
          begin
            mem_req_r  <= 1'b1;
            mem_addr_r <= base_r + fetch_ofs;
          end
          else if (mem_rsp.ack)
          begin
            mem_req_r  <= 1'b0;
            img_r      <= {mem_rsp.data, img_r[127:8]};
            byte_cnt_r <= byte_cnt_r + 4'h1;
            if (byte_cnt_r == 4'hF)
              ld_st_r <= LD_APPLY;
          end
        end
        LD_APPLY:
          ld_st_r <= LD_DONE; // fields land on this edge, done follows
        LD_DONE:
          ld_st_r <= LD_DONE;
        default:
          ld_st_r <= LD_DONE;
      endcase
    end
  end

  // done only once every decoded field already sits in its register
  always_ff @(posedge clk)
  begin
    if (rst_all)
      done_r <= 1'b0;
    else
      done_r <= (ld_st_r == LD_DONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers: reset defaults, image load, software writes

  always_ff @(posedge clk)
  begin
    if (rst_ctl)
    begin
      usb_a_r <= DEF_USB_A; // defaults stand unless an image loads
      usb_b_r <= DEF_USB_B;
      usb_c_r <= DEF_USB_C;
      mac_r   <= DEF_MAC;
      hw_r    <= DEF_HW;
      pin_a_r <= DEF_PIN;
      pin_b_r <= DEF_PIN;
    end
    else if (ld_st_r == LD_APPLY)
    begin
      // only named image bits are copied, reserved ones never reach here
      usb_b_r[UB_U1 +: 8]          <= f2[F2_U1 +: 8];
      usb_b_r[UB_HS_TRIM +: 3]     <= f2[F2_HS_TRIM +: 3];
      usb_b_r[UB_FS_TRIM +: 3]     <= f2[F2_FS_TRIM +: 3];
      usb_a_r[UA_LPM_THR +: 5]     <= f2[F2_LPM_THR +: 5]; // bits 23:21 skipped
      usb_a_r[UA_OVL]              <= f2[F2_OVL];
      usb_a_r[UA_U2X]              <= f2[F2_U2X];
      hw_r[HW_SPDUP]               <= f2[F2_SPDUP];
      mac_r[MC_CLKSTOP]            <= f2[F2_CLKSTOP];
      mac_r[MC_EEE]                <= f2[F2_EEE];
      mac_r[MC_LPIX]               <= f2[F2_LPIX];
      mac_r[MC_ADP]                <= f2[F2_ADP];
      mac_r[MC_DPX]                <= f2[F2_DPX];
      mac_r[MC_SPEED +: 2]         <= f2[F2_SPEED +: 2];
      usb_c_r[UC_SS_DET +: 16]     <= f3[F3_SS_DET +: 16];
      usb_c_r[UC_HS_DET +: 16]     <= f3[F3_HS_DET +: 16];
      pin_a_r[PA_EN +: 8]          <= gpio[G_EN +: 8];
      pin_a_r[PA_BUF +: 8]         <= gpio[G_BUF +: 8];
      pin_b_r[PB_DIR +: 8]         <= gpio[G_DIR +: 8];
      pin_b_r[PB_DAT +: 8]         <= gpio[G_DAT +: 8];
    end
    else if (wr_fire)
    begin
      // without an image software fills the same fields itself
      unique case (wr_idx)
        4'h0: usb_a_r <= wmerge(usb_a_r, axi_req.wdata, axi_req.wstrb, MSK_USB_A);
        4'h1: usb_b_r <= wmerge(usb_b_r, axi_req.wdata, axi_req.wstrb, MSK_USB_B);
        4'h2: usb_c_r <= wmerge(usb_c_r, axi_req.wdata, axi_req.wstrb, MSK_USB_C);
        4'h3: mac_r   <= wmerge(mac_r, axi_req.wdata, axi_req.wstrb, MSK_MAC);
        4'h4: hw_r    <= wmerge(hw_r, axi_req.wdata, axi_req.wstrb, MSK_HW);
        4'h5: pin_a_r <= wmerge(pin_a_r, axi_req.wdata, axi_req.wstrb, MSK_PIN);
        4'h6: pin_b_r <= wmerge(pin_b_r, axi_req.wdata, axi_req.wstrb, MSK_PIN);
        4'h9:
        begin
          // bmAttributes sits in the top byte of the word after the config start
          if (attr_ok && ram_addr_r == RAM_AW'(attr_r[AT_CFG_WORD +: RAM_AW] + 1'b1)
              && axi_req.wstrb[3])
          begin
            usb_a_r[UA_PWR] <= axi_req.wdata[BM_SELF_PWR];
            usb_a_r[UA_RWK] <= axi_req.wdata[BM_RMT_WAKE];
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // attribute register, ram pointer and write-order tracking

  // order matters only for the flag overwrite, so misuse is tolerated, not refused
  always_ff @(posedge clk)
  begin
    if (rst_ctl)
    begin
      attr_r      <= 32'h0000_0000;
      ram_addr_r  <= '0;
      attr_seen_r <= 1'b0;
      ram_early_r <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (wr_idx == 4'h7)
      begin
        attr_r      <= wmerge(attr_r, axi_req.wdata, axi_req.wstrb, MSK_ATTR);
        attr_seen_r <= 1'b1;
      end
      if (wr_idx == 4'h8)
        ram_addr_r <= axi_req.wdata[RAM_AW-1:0];
      if (ram_wr)
      begin
        ram_addr_r <= ram_addr_r + 1'b1; // auto-increment for bulk fill
        if (!attr_seen_r)
          ram_early_r <= 1'b1; // ram before attributes disables overwrite
      end
    end
  end

  // alternate descriptor store filled by software
  ecfl_desc_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW)
  ) u_ram (
    .clk       (clk),
    .clr       (rst_ctl),
    .wr_en     (ram_wr),
    .wr_idx    (ram_addr_r),
    .wr_data   (axi_req.wdata),
    .rd_a_idx  (desc_rd_idx),
    .rd_a_data (desc_rd_data),
    .rd_b_idx  (ram_addr_r),
    .rd_b_data (ram_rd_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: one write and one read in flight

  // write: ready raised a cycle after both channels show valid
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      if (axi_req.awvalid && axi_req.wvalid && !awready_r && !bvalid_r)
      begin
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_r && axi_req.bready)
        bvalid_r <= 1'b0;
    end
  end

  // read: data latched on the address edge
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end
    else
    begin
      arready_r <= axi_req.arvalid && !arready_r && !rvalid_r;
      if (rd_fire)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= (rd_idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
        unique case (rd_idx)
          4'h0: rdata_r <= usb_a_r;
          4'h1: rdata_r <= usb_b_r;
          4'h2: rdata_r <= usb_c_r;
          4'h3: rdata_r <= mac_r;
          4'h4: rdata_r <= hw_r;
          4'h5: rdata_r <= pin_a_r;
          4'h6: rdata_r <= pin_b_r;
          4'h7: rdata_r <= attr_r;
          4'h8: rdata_r <= 32'(ram_addr_r);
          4'h9: rdata_r <= ram_rd_b;
          4'hA: rdata_r <= 32'({attr_ok, src_r, done_r});
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
      else if (rvalid_r && axi_req.rready)
        rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops

  assign axi_rsp.awready    = awready_r;
  assign axi_rsp.wready     = wready_r;
  assign axi_rsp.bvalid     = bvalid_r;
  assign axi_rsp.bresp      = bresp_r;
  assign axi_rsp.arready    = arready_r;
  assign axi_rsp.rvalid     = rvalid_r;
  assign axi_rsp.rdata      = rdata_r;
  assign axi_rsp.rresp      = rresp_r;
  assign mem_req.req        = mem_req_r;
  assign mem_req.otp        = mem_otp_r;
  assign mem_req.addr       = mem_addr_r;
  assign cfg_done           = done_r;
  // descriptors come from ram while the source bit is set
  assign desc_src_ram       = hw_r[HW_DSRC];
  // ids and strings stay with the built-in descriptors, not loaded here
  assign usb_setup_reg_a    = usb_a_r;
  assign usb_setup_reg_b    = usb_b_r;
  assign usb_setup_reg_c    = usb_c_r;
  assign mac_control_reg    = mac_r;
  assign hardware_setup_reg = hw_r;
  assign pin_setup_reg_a    = pin_a_r;
  assign pin_setup_reg_b    = pin_b_r;

endmodule
`default_nettype wire

// ==== common/ecfl_pkg.sv ====
// shared constants, states and carriers of the configuration loader
package ecfl_pkg;

  // register byte offsets on the register bus
  localparam logic [7:0] OFS_USB_A    = 8'h00;
  localparam logic [7:0] OFS_USB_B    = 8'h04;
  localparam logic [7:0] OFS_USB_C    = 8'h08;
  localparam logic [7:0] OFS_MAC      = 8'h0C;
  localparam logic [7:0] OFS_HW       = 8'h10;
  localparam logic [7:0] OFS_PIN_A    = 8'h14;
  localparam logic [7:0] OFS_PIN_B    = 8'h18;
  localparam logic [7:0] OFS_ATTR     = 8'h1C;
  localparam logic [7:0] OFS_RAM_ADDR = 8'h20;
  localparam logic [7:0] OFS_RAM_DATA = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;

  // signatures and image base offsets
  localparam logic [7:0] SIG_EE      = 8'hA5;
  localparam logic [7:0] SIG_OTP_LO  = 8'hF3;
  localparam logic [7:0] SIG_OTP_HI  = 8'hF7;
  localparam logic [9:0] SIG_ADDR    = 10'h000;
  localparam logic [9:0] BASE_EE     = 10'h000;
  localparam logic [9:0] BASE_OTP_LO = 10'h001;
  localparam logic [9:0] BASE_OTP_HI = 10'h101;

  // field positions inside configuration word 2, word 3 and the gpio field
  localparam int F2_U1 = 24, F2_LPM_THR = 16, F2_OVL = 15, F2_U2X = 14, F2_ADP = 13;
  localparam int F2_SPDUP = 12, F2_CLKSTOP = 11, F2_EEE = 10, F2_LPIX = 9, F2_DPX = 8;
  localparam int F2_SPEED = 6, F2_HS_TRIM = 3, F2_FS_TRIM = 0;
  localparam int F3_SS_DET = 16, F3_HS_DET = 0;
  localparam int G_EN = 52, G_BUF = 36, G_DIR = 20, G_DAT = 4;

  // field positions inside the control registers
  localparam int UA_LPM_THR = 0, UA_OVL = 5, UA_U2X = 6, UA_PWR = 7, UA_RWK = 8;
  localparam int UB_U1 = 0, UB_HS_TRIM = 8, UB_FS_TRIM = 11;
  localparam int UC_HS_DET = 0, UC_SS_DET = 16;
  localparam int MC_ADP = 0, MC_DPX = 1, MC_SPEED = 2, MC_CLKSTOP = 4, MC_EEE = 5, MC_LPIX = 6;
  localparam int HW_SPDUP = 0, HW_DSRC = 1, HW_PROT = 2;
  localparam int PA_EN = 0, PA_BUF = 8, PB_DIR = 0, PB_DAT = 8;
  localparam int AT_CFG_WORD = 0, BM_SELF_PWR = 30, BM_RMT_WAKE = 29;
  localparam int ST_DONE = 0, ST_SRC = 1, ST_ATTR_OK = 3;

  // writable bits and reset defaults of each register
  localparam logic [31:0] MSK_USB_A = 32'h0000_01FF;
  localparam logic [31:0] MSK_USB_B = 32'h0000_3FFF;
  localparam logic [31:0] MSK_USB_C = 32'hFFFF_FFFF;
  localparam logic [31:0] MSK_MAC   = 32'h0000_007F;
  localparam logic [31:0] MSK_HW    = 32'h0000_0007;
  localparam logic [31:0] MSK_PIN   = 32'h0000_FFFF;
  localparam logic [31:0] MSK_ATTR  = 32'h0000_007F;
  localparam logic [31:0] DEF_USB_A = 32'h0000_0000;
  localparam logic [31:0] DEF_USB_B = 32'h0000_0000;
  localparam logic [31:0] DEF_USB_C = 32'h0000_0000;
  localparam logic [31:0] DEF_MAC   = 32'h0000_0000;
  localparam logic [31:0] DEF_HW    = 32'h0000_0000;
  localparam logic [31:0] DEF_PIN   = 32'h0000_0000;

  // bus answers and image source codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] SRC_NONE    = 2'b00;
  localparam logic [1:0] SRC_EE      = 2'b01;
  localparam logic [1:0] SRC_OTP     = 2'b10;

  typedef enum logic [2:0] {
    LD_EE_SIG  = 3'b000,
    LD_OTP_SIG = 3'b001,
    LD_FETCH   = 3'b010,
    LD_APPLY   = 3'b011,
    LD_DONE    = 3'b100
  } ecfl_ld_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } ecfl_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ecfl_axi_rsp_t;

  typedef struct packed {
    logic       req;
    logic       otp;
    logic [9:0] addr;
  } ecfl_mem_req_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] data;
  } ecfl_mem_rsp_t;

endpackage

// ==== rtl/ecfl_desc_ram.sv ====
// descriptor ram held in flip-flops, one write port and two read ports
`timescale 1ns/1ps
`default_nettype none
module ecfl_desc_ram #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk,
  input  wire logic          clr,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [31:0]   wr_data,
  input  wire logic [AW-1:0] rd_a_idx,
  output logic      [31:0]   rd_a_data,
  input  wire logic [AW-1:0] rd_b_idx,
  output logic      [31:0]   rd_b_data
);

  logic [31:0] mem_r [DEPTH];

  // storage; clr comes on power-on reset, or on system reset when contents are not protected
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (clr)
        mem_r[i] <= 32'h0000_0000;
      else if (wr_en && wr_idx == AW'(i))
        mem_r[i] <= wr_data;
    end
  end

  // registered read for the usb descriptor engine
  always_ff @(posedge clk)
  begin
    rd_a_data <= mem_r[rd_a_idx];
  end

  // bus read path, registered later by the slave
  assign rd_b_data = mem_r[rd_b_idx];

endmodule
`default_nettype wire

// ==== tb/ecfl_mem_model.sv ====
// behavioural eeprom and otp answering the loader one byte at a time
`timescale 1ns/1ps
`default_nettype none
module ecfl_mem_model
  import ecfl_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic [1:0]              dly,
  input  wire ecfl_pkg::ecfl_mem_req_t mem_req,
  output var  ecfl_pkg::ecfl_mem_rsp_t mem_rsp
);
  logic [7:0] ee [1024];
  logic [7:0] otp [1024];
  logic [1:0] cnt_r = 2'd0;
  logic       gap_r = 1'b0;
  initial mem_rsp = '0;
  ////////////////////////////////////////////////////////////
  // answer dly+1 cycles after the request; data toggles off the ack so a stale byte never matches
  always @(posedge clk)
  begin
    gap_r        <= mem_rsp.ack;
    mem_rsp.ack  <= 1'b0;
    mem_rsp.data <= ~mem_rsp.data;
    if (mem_req.req && !mem_rsp.ack && !gap_r)
      cnt_r <= cnt_r + 2'd1;
    if (mem_req.req && !mem_rsp.ack && !gap_r && cnt_r == dly)
    begin
      cnt_r        <= 2'd0;
      mem_rsp.ack  <= 1'b1;
      mem_rsp.data <= mem_req.otp ? otp[mem_req.addr] : ee[mem_req.addr];
    end
  end
endmodule
`default_nettype wire

// ==== tb/ecfl_loader_monitor.sv ====
// checker of the loader port behaviour
`timescale 1ns/1ps
`default_nettype none
module ecfl_loader_monitor
  import ecfl_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    por_rst,
  input wire ecfl_pkg::ecfl_axi_rsp_t axi_rsp,
  input wire ecfl_pkg::ecfl_mem_req_t mem_req,
  input wire ecfl_pkg::ecfl_mem_rsp_t mem_rsp,
  input wire logic                    cfg_done,
  input wire logic                    desc_src_ram,
  input wire logic [31:0]             hardware_setup_reg
);
  logic first_r;
  // set by either reset, cleared by the first byte answer
  always_ff @(posedge clk)
    if (sys_rst || por_rst) first_r <= 1'b1;
    else if (mem_rsp.ack) first_r <= 1'b0;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);
  ////////////////////////////////////////////////////////////
  sig_first_a: assert property (mem_req.req && first_r |-> mem_req.addr == SIG_ADDR && !mem_req.otp)
    else $error("first fetch is not the signature byte");
  req_hold_a: assert property (mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("memory request dropped early");
  done_hold_a: assert property (cfg_done |=> cfg_done)
    else $error("done fell");
  done_quiet_a: assert property (cfg_done |-> !mem_req.req)
    else $error("fetch after done");
  src_bit_a: assert property (desc_src_ram == hardware_setup_reg[HW_DSRC])
    else $error("source select mismatch");
  hw_resv_a: assert property ((hardware_setup_reg & ~MSK_HW) == 32'h0000_0000)
    else $error("reserved bits set");
  write_resp_a: assert property (axi_rsp.awready && axi_rsp.wready |=> axi_rsp.bvalid)
    else $error("write answer late");
  read_resp_a: assert property (axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");
endmodule
bind ecfl_loader ecfl_loader_monitor mon (.clk, .sys_rst, .por_rst, .axi_rsp, .mem_req, .mem_rsp,
  .cfg_done, .desc_src_ram, .hardware_setup_reg);
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench: image loads from each source, then the software setup path
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ecfl_pkg::*;
  localparam logic [9:0] P2 = 10'h010;
  localparam logic [9:0] P3 = 10'h014;
  localparam logic [9:0] PG = 10'h018;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          por_rst = 1'b1;
  logic [1:0]    dly = 2'd0;
  logic [6:0]    idx = 7'd0;
  ecfl_axi_req_t rq = '{wstrb: 4'hF, default: '0};
  ecfl_axi_rsp_t rs;
  ecfl_mem_req_t mq;
  ecfl_mem_rsp_t ms;
  logic          src, done;
  logic [31:0]   ua, ub, uc, mc, hw, pa, pb, rdd, rd, w2, w3;
  logic [63:0]   g;
  logic [1:0]    rp;
  int            err_total = 0;
  int            tests_run = 0;
  // per source: eeprom signature, otp signature, otp base, reported source
  logic [7:0]    es [4] = '{SIG_EE, 8'hA4, 8'h5A, 8'h00};
  logic [7:0]    os [4] = '{8'h00, SIG_OTP_LO, SIG_OTP_HI, 8'h3C};
  logic [9:0]    ob [4] = '{BASE_OTP_LO, BASE_OTP_LO, BASE_OTP_HI, BASE_OTP_LO};
  logic [1:0]    sc [4] = '{SRC_EE, SRC_OTP, SRC_OTP, SRC_NONE};
  always #2 clk = ~clk;
  ecfl_loader #(.F2_OFS(P2), .F3_OFS(P3), .GPIO_OFS(PG)) DUT (.clk, .sys_rst, .por_rst, .axi_req(rq),
    .axi_rsp(rs), .mem_req(mq), .mem_rsp(ms), .desc_rd_idx(idx), .desc_rd_data(rdd), .desc_src_ram(src),
    .cfg_done(done), .usb_setup_reg_a(ua), .usb_setup_reg_b(ub), .usb_setup_reg_c(uc), .mac_control_reg(mc),
    .hardware_setup_reg(hw), .pin_setup_reg_a(pa), .pin_setup_reg_b(pb));
  ecfl_mem_model mem (.clk, .dly, .mem_req(mq), .mem_rsp(ms));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    $display("[FAIL] handshake expected 1 seen 0");
    wrap_up();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ready is read at the edge itself, before that edge's updates land
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rq.awaddr  <= a;
    rq.wdata   <= d;
    rq.awvalid <= 1'b1;
    rq.wvalid  <= 1'b1;
    do @(posedge clk); while (!(rs.awready === 1'b1 && rs.wready === 1'b1) && n++ < 200);
    rq.awvalid <= 1'b0;
    rq.wvalid  <= 1'b0;
    rq.bready  <= 1'b1;
    do @(posedge clk); while (rs.bvalid !== 1'b1 && n++ < 200);
    rq.bready  <= 1'b0;
    if (n > 200) hang();
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    rq.araddr  <= a;
    rq.arvalid <= 1'b1;
    do @(posedge clk); while (rs.arready !== 1'b1 && n++ < 200);
    rq.arvalid <= 1'b0;
    rq.rready  <= 1'b1;
    do @(posedge clk); while (rs.rvalid !== 1'b1 && n++ < 200);
    rq.rready  <= 1'b0;
    rd = rs.rdata;
    rp = rs.rresp;
    if (n > 200) hang();
  endtask
  // signature at byte 0, words little-endian from the base
  task automatic put(input logic o, input logic [9:0] b, input logic [7:0] s);
    if (o) mem.otp[0] = s;
    else mem.ee[0] = s;
    for (int i = 0; i < 8; i++)
      if (o) {mem.otp[b+P2+i%4], mem.otp[b+P3+i%4], mem.otp[b+PG+i]} = {w2[8*(i%4)+:8], w3[8*(i%4)+:8], g[8*i+:8]};
      else {mem.ee[b+P2+i%4], mem.ee[b+P3+i%4], mem.ee[b+PG+i]} = {w2[8*(i%4)+:8], w3[8*(i%4)+:8], g[8*i+:8]};
  endtask
  task automatic boot(input logic p);
    int n;
    n = 0;
    if (p) por_rst <= 1'b1;
    else sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    por_rst <= 1'b0;
    sys_rst <= 1'b0;
    do @(posedge clk); while (done !== 1'b1 && n++ < 500);
    if (n > 500) hang();
  endtask
  task automatic regs(input logic l);
    chk("usb_a", {32{l}} & {25'd0, w2[14], w2[15], w2[20:16]}, ua);
    chk("usb_b", {32{l}} & {18'd0, w2[2:0], w2[5:3], w2[31:24]}, ub);
    chk("usb_c", {32{l}} & w3, uc);
    chk("mac", {32{l}} & {25'd0, w2[9], w2[10], w2[11], w2[7:6], w2[8], w2[13]}, mc);
    chk("hw", {32{l}} & {31'd0, w2[12]}, hw);
    chk("pin_a", {32{l}} & {16'd0, g[43:36], g[59:52]}, pa);
    chk("pin_b", {32{l}} & {16'd0, g[11:4], g[27:20]}, pb);
  endtask
  ////////////////////////////////////////////////////////////
  // each image source in turn, slower memory each time
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    for (int m = 0; m < 4; m++)
    begin
      dly <= m[1:0];
      w2 = 32'hDEE5_A6F9 ^ {16{m[1:0]}};
      w3 = 32'h8C1F_4B27 + m;
      g  = {w2, ~w3};
      put(1'b0, BASE_EE, es[m]);
      put(1'b1, ob[m], os[m]);
      boot(1'b1);
      regs(m < 3);
      axr(OFS_STATUS);
      chk("status", {28'd0, 1'b0, sc[m], 1'b1}, rd);
    end
    axw(OFS_ATTR, 32'h0000_0004);
    axw(OFS_RAM_ADDR, 32'h0000_0005);
    axw(OFS_RAM_DATA, 32'h6000_0000);
    axr(OFS_USB_A);
    chk("usb_a", 32'h0000_0180, rd);
    idx <= 7'd5;
    repeat (2) @(posedge clk);
    chk("desc_rd", 32'h6000_0000, rdd);
    axw(OFS_RAM_ADDR, 32'h0000_0005);
    axr(OFS_RAM_DATA);
    chk("ram_data", 32'h6000_0000, rd);
    axw(OFS_USB_C, 32'h1234_ABCD);
    axw(OFS_HW, 32'h0000_0006);
    boot(1'b0);
    chk("usb_c", 32'h1234_ABCD, uc);
    chk("src", 32'h0000_0001, {31'd0, src});
    boot(1'b1);
    chk("usb_c", 32'h0000_0000, uc);
    // ram written before the attribute register: flags must stay clear
    axw(OFS_RAM_DATA, 32'h0000_0000);
    axw(OFS_ATTR, 32'h0000_0004);
    axw(OFS_RAM_ADDR, 32'h0000_0005);
    axw(OFS_RAM_DATA, 32'h6000_0000);
    axr(OFS_USB_A);
    chk("usb_a", 32'h0000_0000, rd);
    axr(8'h3C);
    chk("unmapped", {30'd0, RESP_SLVERR}, {30'd0, rp});
    wrap_up();
  end
endmodule
`default_nettype wire
